// >>> cpu_gate_partner.sv
`timescale 1ns/100ps
module cpu_gate_partner
    import phase_mgr_pkg::*;
(
    // clock
    input wire logic clk,
    // gate driver inputs, phase 4 down to 1
    input wire logic [3:0] gates,
    // processor voltage code
    output logic [VID_W-1:0] voltageIdCode = 8'h10
);
    int cycle = 0;
    int riseAt [4] = '{default: 0};
    int highCnt [4] = '{default: 0};
    logic [3:0] gatesPrev = 4'h0;

    // one driver per output: last turn-on cycle and total on-time
    always @(posedge clk) begin
        cycle <= cycle + 1;
        gatesPrev <= gates;
        for (int i = 0; i < 4; i++) begin
            if (gates[i]) begin
                highCnt[i] <= highCnt[i] + 1;
            end
            if (gates[i] && !gatesPrev[i]) begin
                riseAt[i] <= cycle;
            end
        end
    end

    // code moves just after an edge, then stays well past the settle time
    task automatic setCode(input logic [VID_W-1:0] c);
        @(posedge clk);
        voltageIdCode <= c;
        repeat (12) @(posedge clk);
    endtask : setCode
endmodule : cpu_gate_partner

// >>> multiphase_pwm_phase_manager.sv
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/100ps
module multiphase_pwm_phase_manager
    import phase_mgr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    // processor side
    input wire logic [VID_W-1:0] voltageIdCode,
    input wire logic autoSaveEnable,
    input wire logic powerSaveRequestN,
    input wire logic savePhaseCountSelect,
    // converter sensing
    input wire logic enableIn,
    input wire logic [7:0] supplyLevel,
    input wire logic [7:0] errorLevel,
    input wire logic [11:0] summedPhaseCurrent,
    input wire logic [11:0] outputMv,
    input wire logic [11:0] targetMv,
    // gate drivers and status
    output logic gateOutPhase1,
    output logic gateOutPhase2,
    output logic gateOutPhase3,
    output logic gateOutPhase4,
    output logic softStartEnable,
    output logic regulatorReady
);
    typedef struct packed {
        run_state_t state;
        logic supplyOk;
        logic [2:0] cfgPhases;
        logic [7:0] period;
        logic [11:0] limit;
        logic [IRQ_W-1:0] irqStat;
        logic [IRQ_W-1:0] irqMask;
        logic [7:0] cnt;
        logic autoSave;
        logic saveMode;
        logic [3:0] gates;
        logic ack;
        logic [31:0] rdat;
    } mgr_t;

    mgr_t s_r;
    mgr_t s_nxt;
    vid_if vid ();

    vid_change_watcher u_watch (
        .clk(clk),
        .resetn(resetn),
        .voltageIdCode(voltageIdCode),
        .vid(vid.watcher)
    );

    // start of slot s when k phases share one period
    function automatic logic [7:0] phaseOffset(input logic [7:0] per,
                                               input logic [2:0] k,
                                               input logic [1:0] slot);
        logic [9:0] prod;
        prod = 10'(slot) * 10'(per);
        case (k)
            3'h2: phaseOffset = 8'(prod >> 1);
            3'h3: phaseOffset = 8'(prod / 10'h003);
            3'h4: phaseOffset = 8'(prod >> 2);
            default: phaseOffset = 8'h00;
        endcase
    endfunction : phaseOffset

    // which ramp slot drives output i, and whether it is used at all
    function automatic logic [2:0] slotMap(input logic [2:0] k, input logic [1:0] i);
        case (k)
            3'h1: slotMap = (i == 2'h0) ? 3'b100 : 3'b000;
            3'h2: slotMap = (i == 2'h0) ? 3'b100 : (i == 2'h2) ? 3'b101 : 3'b000;
            3'h3: slotMap = (i == 2'h3) ? 3'b000 : {1'b1, i};
            3'h4: slotMap = {1'b1, i};
            default: slotMap = 3'b000;
        endcase
    endfunction : slotMap

    // symmetric triangle: peak at period edges, valley mid-period
    function automatic logic [7:0] rampLevel(input logic [7:0] per, input logic [7:0] pos);
        logic [7:0] half;
        half = per >> 1;
        rampLevel = (pos <= half) ? (half - pos) : (pos - half);
    endfunction : rampLevel

    // a phase-count field outside 2..4 is taken as four phases
    function automatic logic [2:0] validPhases(input logic [2:0] v);
        validPhases = (v == 3'h2 || v == 3'h3) ? v : PHASES_RESET;
    endfunction : validPhases

    logic [2:0] keptPhases;
    logic [14:0] limitProd;
    logic [11:0] effLimit;
    logic [12:0] ovLevel;
    logic ocTrip;
    logic ovTrip;
    logic busHit;
    logic [7:0] pos;
    logic [8:0] posSum;
    logic [2:0] map;
    logic [7:0] newPer;
    logic [IRQ_W-1:0] irqSet;
    logic [IRQ_W-1:0] irqClr;

    // phases kept after shedding, never more than fitted
    always_comb begin
        if (s_r.saveMode) begin
            keptPhases = savePhaseCountSelect ? 3'h1 : 3'h2; // RL6
        end else begin
            keptPhases = s_r.cfgPhases; // RL7
        end
    end

    // overcurrent limit follows the share of phases still running
    always_comb begin
        limitProd = 15'(s_r.limit) * 15'(keptPhases); // RL3
        case (s_r.cfgPhases)
            3'h2: effLimit = 12'(limitProd >> 1);
            3'h3: effLimit = 12'(limitProd / 15'h0003);
            default: effLimit = 12'(limitProd >> 2);
        endcase
        ocTrip = summedPhaseCurrent > effLimit; // RL12
        ovLevel = 13'(targetMv) + OV_MARGIN_MV;
        ovTrip = 13'(outputMv) > ovLevel; // RL14
    end

    // main next-state process
    always_comb begin
        s_nxt = s_r;
        busHit = wb_cyc_i && wb_stb_i && !s_r.ack;
        irqSet = '0;
        irqClr = '0;
        pos = 8'h00;
        posSum = 9'h000;
        map = 3'h0;
        newPer = wb_dat_i[7:0];

        // supply comparator with hysteresis
        if (!s_r.supplyOk && supplyLevel >= SUPPLY_LOCKOUT_RISE) begin
            s_nxt.supplyOk = 1'b1; // RL11
        end else if (s_r.supplyOk && supplyLevel < SUPPLY_LOCKOUT_FALL) begin
            s_nxt.supplyOk = 1'b0; // RL11
        end

        // forced request wins; auto detection only while enabled
        if (!autoSaveEnable) begin
            s_nxt.autoSave = 1'b0; // RL4
        end else if (vid.dropPulse) begin
            s_nxt.autoSave = 1'b1; // RL1
        end else if (vid.risePulse) begin
            s_nxt.autoSave = 1'b0; // RL2
        end
        s_nxt.saveMode = !powerSaveRequestN || (powerSaveRequestN && s_nxt.autoSave); // RL5
        irqSet[IRQ_SAVE_IN] = s_nxt.saveMode && !s_r.saveMode;
        irqSet[IRQ_SAVE_OUT] = !s_nxt.saveMode && s_r.saveMode;

        // run state; from run, overvoltage outranks everything and only reset clears it
        case (s_r.state)
            ST_LOCKOUT: begin
                if (s_r.supplyOk && enableIn) begin
                    s_nxt.state = ST_RUN; // RL11
                end
            end
            ST_RUN: begin
                if (ovTrip) begin
                    s_nxt.state = ST_OV_TRIP; // RL14
                    irqSet[IRQ_OV] = 1'b1;
                end else if (!s_r.supplyOk || !enableIn) begin
                    s_nxt.state = ST_LOCKOUT; // RL11
                end else if (ocTrip) begin
                    s_nxt.state = ST_OC_TRIP; // RL12
                    irqSet[IRQ_OC] = 1'b1;
                end
            end
            ST_OC_TRIP: begin
                if (!enableIn) begin
                    s_nxt.state = ST_LOCKOUT; // RL13
                end
            end
            ST_OV_TRIP: begin
                s_nxt.state = ST_OV_TRIP; // RL14
            end
            default: begin
                s_nxt.state = ST_LOCKOUT;
            end
        endcase

        // shared period counter; a shortened period wraps at once
        if (s_r.cnt >= s_r.period - 8'h01) begin
            s_nxt.cnt = 8'h00; // RL9
        end else begin
            s_nxt.cnt = s_r.cnt + 8'h01;
        end

        // per-output comparators against offset ramps
        for (int i = 0; i < 4; i++) begin
            map = slotMap(keptPhases, 2'(i)); // RL7
            // nine bits: counter plus offset passes 255 at long periods
            posSum = 9'(s_r.cnt) + 9'(phaseOffset(s_r.period, keptPhases, map[1:0])); // RL8
            if (posSum >= 9'(s_r.period)) begin
                posSum = posSum - 9'(s_r.period);
            end
            pos = posSum[7:0];
            s_nxt.gates[i] = (s_r.state == ST_RUN) && map[2] // RL12
                && (errorLevel > rampLevel(s_r.period, pos)); // RL10
        end

        // wishbone: one wait state, ack for one cycle
        s_nxt.ack = busHit;
        if (busHit && !wb_we_i) begin
            s_nxt.rdat = 32'h0;
            case (wb_adr_i)
                ADDR_CTRL: s_nxt.rdat[2:0] = s_r.cfgPhases;
                ADDR_PERIOD: s_nxt.rdat[7:0] = s_r.period;
                ADDR_LIMIT: s_nxt.rdat[11:0] = s_r.limit;
                ADDR_STATUS: begin
                    s_nxt.rdat[STAT_STATE_LSB +: 2] = s_r.state;
                    s_nxt.rdat[STAT_SAVE] = s_r.saveMode;
                    s_nxt.rdat[STAT_KEPT_LSB +: 3] = keptPhases;
                    s_nxt.rdat[STAT_VID_LSB +: VID_W] = vid.stableCode;
                end
                ADDR_IRQ_STAT: s_nxt.rdat[IRQ_W-1:0] = s_r.irqStat;
                ADDR_IRQ_MASK: s_nxt.rdat[IRQ_W-1:0] = s_r.irqMask;
                default: s_nxt.rdat = 32'h0;
            endcase
        end
        if (busHit && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                ADDR_CTRL: s_nxt.cfgPhases = validPhases(wb_dat_i[2:0]);
                ADDR_PERIOD: begin
                    // clamp keeps the oscillator inside its range
                    if (newPer < PER_MIN) begin
                        s_nxt.period = PER_MIN; // RL9
                    end else if (newPer > PER_MAX) begin
                        s_nxt.period = PER_MAX; // RL9
                    end else begin
                        s_nxt.period = newPer;
                    end
                end
                ADDR_LIMIT: s_nxt.limit[7:0] = wb_dat_i[7:0];
                ADDR_IRQ_STAT: irqClr = wb_dat_i[IRQ_W-1:0];
                ADDR_IRQ_MASK: s_nxt.irqMask = wb_dat_i[IRQ_W-1:0];
                default: s_nxt.irqMask = s_r.irqMask;
            endcase
        end
        if (busHit && wb_we_i && wb_sel_i[1] && wb_adr_i == ADDR_LIMIT) begin
            s_nxt.limit[11:8] = wb_dat_i[11:8];
        end

        // an event in the clearing cycle survives the clear
        s_nxt.irqStat = (s_r.irqStat & ~irqClr) | irqSet;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_r <= '{state: ST_LOCKOUT, supplyOk: 1'b0, cfgPhases: PHASES_RESET,
                     period: PER_RESET, limit: LIMIT_RESET, irqStat: '0, irqMask: '0,
                     cnt: 8'h00, autoSave: 1'b0, saveMode: 1'b0, gates: 4'h0,
                     ack: 1'b0, rdat: 32'h0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign wb_ack_o = s_r.ack;
    assign wb_dat_o = s_r.rdat;
    assign irq = |(s_r.irqStat & s_r.irqMask);
    assign gateOutPhase1 = s_r.gates[0];
    assign gateOutPhase2 = s_r.gates[1];
    assign gateOutPhase3 = s_r.gates[2];
    assign gateOutPhase4 = s_r.gates[3];
    assign softStartEnable = (s_r.state == ST_RUN); // RL12
    assign regulatorReady = (s_r.state == ST_RUN); // RL14

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_gates_idle_low: assert property ((s_r.state != ST_RUN) |=> (s_r.gates == 4'h0)) // RL11
        else $error("gate high outside run");
    a_lockout_holds: assert property ((s_r.state == ST_LOCKOUT && !s_r.supplyOk) // RL11
        |=> (s_r.state == ST_LOCKOUT)) else $error("left lockout below threshold");
    a_oc_latch_set: assert property ((s_r.state == ST_RUN && ocTrip && !ovTrip // RL12
        && s_r.supplyOk && enableIn) |=> (s_r.state == ST_OC_TRIP ##1 s_r.gates == 4'h0))
        else $error("overcurrent not latched");
    a_oc_latch_hold: assert property ((s_r.state == ST_OC_TRIP && enableIn) // RL13
        |=> (s_r.state == ST_OC_TRIP)) else $error("overcurrent latch lost");
    a_ov_sticky: assert property ((s_r.state == ST_OV_TRIP) |=> (s_r.state == ST_OV_TRIP // RL14
        && !regulatorReady)) else $error("overvoltage latch lost");
    a_forced_save: assert property (!powerSaveRequestN |=> s_r.saveMode) // RL5
        else $error("forced save not taken");
    a_auto_enter: assert property ((autoSaveEnable && vid.dropPulse) |=> s_r.autoSave) // RL1
        else $error("auto save not entered");
    a_auto_exit: assert property ((autoSaveEnable && powerSaveRequestN && vid.risePulse // RL2
        && !vid.dropPulse) |=> !s_r.saveMode) else $error("auto save not left");
    a_auto_disabled: assert property ((!autoSaveEnable && powerSaveRequestN) // RL4
        |=> !s_r.saveMode) else $error("save mode without request");
    a_two_phase_map: assert property ((s_r.cfgPhases == 3'h2) // RL7
        |=> (!s_r.gates[1] && !s_r.gates[3])) else $error("unused output driven");
    a_one_phase_keep: assert property ((s_r.saveMode && savePhaseCountSelect) // RL6
        |=> (s_r.gates[3:1] == 3'h0)) else $error("more than one phase kept");
    a_zero_error_low: assert property ((errorLevel == 8'h00) |=> (s_r.gates == 4'h0)) // RL10
        else $error("gate high with zero error");
    a_period_range: assert property ((s_r.period >= PER_MIN && s_r.period <= PER_MAX)) // RL9
        else $error("period out of range");
    a_ack_one_cycle: assert property (s_r.ack |=> !s_r.ack)
        else $error("ack longer than one cycle");
    // phase mapping, protection paths, phase shedding and auto enable
    a_three_phase_map: assert property ((s_r.cfgPhases == 3'h3) |=> !s_r.gates[3]) // RL7
        else $error("fourth output driven");
    a_two_kept_map: assert property ((s_r.saveMode && !savePhaseCountSelect) // RL6
        |=> (!s_r.gates[1] && !s_r.gates[3])) else $error("shed output driven");
    a_limit_scaled: assert property ((s_r.saveMode && savePhaseCountSelect // RL3
        && s_r.cfgPhases == 3'h4) |-> (effLimit == (s_r.limit >> 2)))
        else $error("limit not scaled");
    a_oc_gates_low: assert property ((s_r.state == ST_OC_TRIP) // RL12
        |=> (s_r.gates == 4'h0 && !softStartEnable)) else $error("output live after trip");
    a_oc_release: assert property ((s_r.state == ST_OC_TRIP && !enableIn) // RL13
        |=> (s_r.state == ST_LOCKOUT)) else $error("trip kept with enable low");
    a_ov_entry: assert property ((s_r.state == ST_RUN && ovTrip) // RL14
        |=> (s_r.state == ST_OV_TRIP)) else $error("overvoltage not latched");
    a_supply_rise: assert property ((!s_r.supplyOk && supplyLevel >= SUPPLY_LOCKOUT_RISE) // RL11
        |=> s_r.supplyOk) else $error("supply rise missed");
    a_supply_hyst: assert property ((s_r.supplyOk && supplyLevel >= SUPPLY_LOCKOUT_FALL) // RL11
        |=> s_r.supplyOk) else $error("supply lost inside hysteresis");
    a_auto_off: assert property (!autoSaveEnable |=> !s_r.autoSave) // RL4
        else $error("auto state kept while disabled");

    c_oc_trip: cover property (s_r.state == ST_RUN ##1 s_r.state == ST_OC_TRIP);
    c_ov_trip: cover property (s_r.state == ST_RUN ##1 s_r.state == ST_OV_TRIP);
    c_auto_round: cover property (vid.dropPulse ##[1:200] vid.risePulse);
    c_four_run: cover property (s_r.state == ST_RUN && s_r.cfgPhases == 3'h4 && s_r.gates[3]);
endmodule : multiphase_pwm_phase_manager

// >>> phase_mgr_pkg.sv
// Operation
// RL1: auto save enters on voltage code drop
// RL2: auto save leaves on voltage code rise
// RL3: save mode scales current limit by phases
// RL4: auto enable input, below forced request
// RL5: low save request forces save mode
// RL6: select high keeps one, low two
// RL7: 2/3/4 phases; unused outputs stay low
// RL8: ramps offset evenly: 180, 120, 90 degrees
// RL9: switching period spans 100 kHz to 1 MHz
// RL10: gate high while error exceeds ramp
// RL11: supply lockout holds outputs, with hysteresis
// RL12: overcurrent latches outputs and soft start low
// RL13: overcurrent clears by power or enable toggle
// RL14: overvoltage drops ready, latches until power
// RL15: voltage code synchronised, compared stable-to-stable
package phase_mgr_pkg;
    // clock and switching range
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned FSW_MIN_KHZ = 100;
    localparam int unsigned FSW_MAX_KHZ = 1000;
    // longest period rounds down, shortest rounds up
    localparam logic [7:0] PER_MAX = 8'(CLK_HZ / (FSW_MIN_KHZ * 1000));
    localparam logic [7:0] PER_MIN = 8'((CLK_HZ + FSW_MAX_KHZ * 1000 - 1) / (FSW_MAX_KHZ * 1000));
    localparam logic [7:0] PER_RESET = 8'h4c;
    // protection thresholds
    localparam logic [12:0] OV_MARGIN_MV = 13'h0b4;
    localparam logic [7:0] SUPPLY_LOCKOUT_RISE = 8'hb0;
    localparam logic [7:0] SUPPLY_LOCKOUT_FALL = 8'ha0;
    // voltage code watcher
    localparam int unsigned VID_W = 8;
    localparam logic [2:0] VID_STABLE_CYC = 3'h4;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PERIOD = 8'h04;
    localparam logic [7:0] ADDR_LIMIT = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    // fields and reset values
    localparam logic [2:0] PHASES_RESET = 3'h4;
    localparam logic [11:0] LIMIT_RESET = 12'hfff;
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_OC = 0;
    localparam int unsigned IRQ_OV = 1;
    localparam int unsigned IRQ_SAVE_IN = 2;
    localparam int unsigned IRQ_SAVE_OUT = 3;
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_SAVE = 2;
    localparam int unsigned STAT_KEPT_LSB = 4;
    localparam int unsigned STAT_VID_LSB = 8;

    typedef enum logic [1:0] {
        ST_LOCKOUT,
        ST_RUN,
        ST_OC_TRIP,
        ST_OV_TRIP
    } run_state_t;
endpackage : phase_mgr_pkg

// >>> test_multiphase_pwm_phase_manager.sv
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_multiphase_pwm_phase_manager;
    import phase_mgr_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [3:0] wbSel = 4'h0;
    logic [7:0] wbAdr = 8'h00;
    logic [31:0] wbDat = 32'h0;
    logic [31:0] wbRdat;
    logic wbAck;
    logic irq;
    logic autoSaveEnable = 1'b0;
    logic powerSaveRequestN = 1'b1;
    logic savePhaseCountSelect = 1'b0;
    logic enableIn = 1'b1;
    logic [7:0] supplyLevel = 8'h00;
    logic [7:0] errorLevel = 8'h00;
    logic [11:0] summedPhaseCurrent = 12'h000;
    logic [11:0] outputMv = 12'h100;
    logic [11:0] targetMv = 12'h100;
    logic [3:0] gates;
    logic softStartEnable;
    logic regulatorReady;
    logic [VID_W-1:0] vidCode;
    logic [31:0] rd;
    logic [3:0] patt [5] = '{4'h0, 4'h1, 4'h5, 4'h7, 4'hf};
    int miscompares = 0;
    int comparisons = 0;
    int h;

    always #20 clk = ~clk;

    multiphase_pwm_phase_manager dut_u (.clk(clk), .resetn(resetn), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
        .wb_dat_o(wbRdat), .wb_ack_o(wbAck), .irq(irq), .voltageIdCode(vidCode),
        .autoSaveEnable(autoSaveEnable), .powerSaveRequestN(powerSaveRequestN),
        .savePhaseCountSelect(savePhaseCountSelect), .enableIn(enableIn),
        .supplyLevel(supplyLevel), .errorLevel(errorLevel),
        .summedPhaseCurrent(summedPhaseCurrent), .outputMv(outputMv), .targetMv(targetMv),
        .gateOutPhase1(gates[0]), .gateOutPhase2(gates[1]), .gateOutPhase3(gates[2]),
        .gateOutPhase4(gates[3]), .softStartEnable(softStartEnable),
        .regulatorReady(regulatorReady));

    cpu_gate_partner partnerU (.clk(clk), .gates(gates), .voltageIdCode(vidCode));

    task automatic final_report();
        if (miscompares == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    // one classic cycle; the wait for ack is bounded
    task automatic wbx(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int n;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbSel <= 4'hf;
        wbAdr <= adr;
        wbDat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbRdat;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            final_report();
        end
    endtask : wbx

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] e);
        wbx(1'b0, adr, 32'h0);
        `CHK(rd, e)
    endtask : rdchk

    // phases active, save flag, state; the code field is left out
    task automatic stchk(input logic [2:0] ph, input logic sv, input logic [1:0] st);
        wbx(1'b0, ADDR_STATUS, 32'h0);
        `CHK({rd[6:4], rd[2:0]}, {ph, sv, st})
    endtask : stchk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // cycles by which output i turns on before output 1, over a 40-cycle period
    function automatic int lead(input int i);
        return ((partnerU.riseAt[0] - partnerU.riseAt[i]) % 40 + 40) % 40;
    endfunction : lead

    initial begin
        tick(12);
        resetn <= 1'b1;
        rdchk(ADDR_CTRL, 32'(PHASES_RESET));
        rdchk(ADDR_PERIOD, 32'(PER_RESET));
        rdchk(ADDR_LIMIT, 32'(LIMIT_RESET));
        rdchk(ADDR_IRQ_MASK, 32'h0);
        wbx(1'b1, 8'h18, 32'hffff_ffff);
        rdchk(8'h18, 32'h0);
        // supply threshold and hysteresis
        errorLevel <= 8'hff;
        supplyLevel <= 8'haf;
        tick(4);
        stchk(3'h4, 1'b0, 2'h0);
        `CHK(gates, 4'h0)
        supplyLevel <= 8'hb0;
        tick(4);
        stchk(3'h4, 1'b0, 2'h1);
        `CHK({softStartEnable, regulatorReady}, 2'b11)
        supplyLevel <= 8'ha0;
        tick(4);
        stchk(3'h4, 1'b0, 2'h1);
        supplyLevel <= 8'h9f;
        tick(4);
        stchk(3'h4, 1'b0, 2'h0);
        supplyLevel <= 8'hb0;
        // period range clamps at both ends
        wbx(1'b1, ADDR_PERIOD, 32'h5);
        rdchk(ADDR_PERIOD, 32'(PER_MIN));
        wbx(1'b1, ADDR_PERIOD, 32'hff);
        rdchk(ADDR_PERIOD, 32'(PER_MAX));
        wbx(1'b1, ADDR_PERIOD, 32'd40);
        wbx(1'b1, ADDR_CTRL, 32'h1);
        rdchk(ADDR_CTRL, 32'h4);
        // each phase count: mapping, spacing and duty
        for (int k = 2; k <= 4; k++) begin
            wbx(1'b1, ADDR_CTRL, 32'(k));
            errorLevel <= 8'hff;
            tick(4);
            `CHK(gates, patt[k])
            errorLevel <= 8'h01;
            tick(90);
            for (int i = 1; i < 4; i++) begin
                if (patt[k][i]) `CHK(lead(i), ((k == 2 ? i / 2 : i) * 40) / k)
            end
            errorLevel <= 8'h05;
            tick(2);
            h = partnerU.highCnt[0];
            tick(40);
            `CHK(partnerU.highCnt[0] - h, 9)
        end
        // forced save overrides a disabled auto mode
        errorLevel <= 8'hff;
        powerSaveRequestN <= 1'b0;
        savePhaseCountSelect <= 1'b1;
        tick(4);
        stchk(3'h1, 1'b1, 2'h1);
        `CHK(gates, 4'h1)
        savePhaseCountSelect <= 1'b0;
        tick(4);
        stchk(3'h2, 1'b1, 2'h1);
        `CHK(gates, 4'h5)
        powerSaveRequestN <= 1'b1;
        tick(4);
        stchk(3'h4, 1'b0, 2'h1);
        rdchk(ADDR_IRQ_STAT, 32'hc);
        wbx(1'b1, ADDR_IRQ_STAT, 32'hf);
        wbx(1'b1, ADDR_IRQ_MASK, 32'h4);
        // automatic entry on a drop, exit on a rise
        autoSaveEnable <= 1'b1;
        partnerU.setCode(8'h20);
        stchk(3'h2, 1'b1, 2'h1);
        `CHK(rd[15:8], 8'h20)
        `CHK(irq, 1'b1)
        wbx(1'b1, ADDR_IRQ_STAT, 32'h4);
        tick(2);
        `CHK(irq, 1'b0)
        partnerU.setCode(8'h08);
        stchk(3'h4, 1'b0, 2'h1);
        rdchk(ADDR_IRQ_STAT, 32'h8);
        autoSaveEnable <= 1'b0;
        partnerU.setCode(8'h30);
        stchk(3'h4, 1'b0, 2'h1);
        // limit scaled down to one phase of four
        wbx(1'b1, ADDR_LIMIT, 32'h400);
        wbx(1'b1, ADDR_IRQ_MASK, 32'h1);
        summedPhaseCurrent <= 12'h101;
        tick(4);
        stchk(3'h4, 1'b0, 2'h1);
        powerSaveRequestN <= 1'b0;
        savePhaseCountSelect <= 1'b1;
        summedPhaseCurrent <= 12'h100;
        tick(4);
        stchk(3'h1, 1'b1, 2'h1);
        summedPhaseCurrent <= 12'h101;
        tick(4);
        stchk(3'h1, 1'b1, 2'h2);
        `CHK({irq, gates, softStartEnable}, 6'b100000)
        summedPhaseCurrent <= 12'h000;
        powerSaveRequestN <= 1'b1;
        tick(4);
        stchk(3'h4, 1'b0, 2'h2);
        enableIn <= 1'b0;
        tick(4);
        stchk(3'h4, 1'b0, 2'h0);
        enableIn <= 1'b1;
        tick(4);
        stchk(3'h4, 1'b0, 2'h1);
        // overvoltage margin edge, latch survives enable toggle
        outputMv <= 12'h1b4;
        tick(4);
        stchk(3'h4, 1'b0, 2'h1);
        outputMv <= 12'h1b5;
        tick(4);
        stchk(3'h4, 1'b0, 2'h3);
        `CHK({regulatorReady, gates}, 5'h00)
        outputMv <= 12'h100;
        enableIn <= 1'b0;
        tick(4);
        enableIn <= 1'b1;
        tick(4);
        stchk(3'h4, 1'b0, 2'h3);
        resetn <= 1'b0;
        tick(12);
        resetn <= 1'b1;
        tick(4);
        stchk(3'h4, 1'b0, 2'h1);
        final_report();
    end
endmodule : test_multiphase_pwm_phase_manager

// >>> vid_change_watcher.sv
`timescale 1ns/100ps
module vid_change_watcher
    import phase_mgr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // processor voltage code pins
    input wire logic [VID_W-1:0] voltageIdCode,
    // settled code to the manager
    vid_if.watcher vid
);
    typedef struct packed {
        logic [VID_W-1:0] sync1;
        logic [VID_W-1:0] sync2;
        logic [VID_W-1:0] last;
        logic [2:0] cnt;
        logic [VID_W-1:0] stable;
        logic valid;
        logic drop;
        logic rise;
    } watch_t;

    watch_t s_r;
    watch_t s_nxt;

    // a larger code means a lower voltage; a code must hold a few cycles
    // so that skew between the pins does not read as two steps
    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = voltageIdCode;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.drop = 1'b0;
        s_nxt.rise = 1'b0;
        if (s_r.sync2 != s_r.last) begin
            s_nxt.last = s_r.sync2;
            s_nxt.cnt = 3'h0;
        end else if (s_r.cnt < VID_STABLE_CYC - 3'h1) begin
            s_nxt.cnt = s_r.cnt + 3'h1;
        end else if (s_r.cnt == VID_STABLE_CYC - 3'h1) begin
            s_nxt.cnt = VID_STABLE_CYC;
            s_nxt.stable = s_r.last;
            s_nxt.valid = 1'b1;
            s_nxt.drop = s_r.valid && (s_r.last > s_r.stable); // RL15
            s_nxt.rise = s_r.valid && (s_r.last < s_r.stable); // RL15
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign vid.stableCode = s_r.stable;
    assign vid.dropPulse = s_r.drop;
    assign vid.risePulse = s_r.rise;

    a_dir_exclusive: assert property (@(posedge clk) disable iff (!resetn) // RL15
        !(s_r.drop && s_r.rise)) else $error("drop and rise together");
    a_drop_is_higher: assert property (@(posedge clk) disable iff (!resetn) // RL15
        s_r.drop |-> (s_r.stable > $past(s_r.stable))) else $error("drop without higher code");
endmodule : vid_change_watcher

// >>> vid_if.sv
`timescale 1ns/100ps
// settled voltage code and its direction events
interface vid_if;
    import phase_mgr_pkg::*;
    logic [VID_W-1:0] stableCode;
    logic dropPulse;
    logic risePulse;
    modport watcher (output stableCode, output dropPulse, output risePulse);
    modport user (input stableCode, input dropPulse, input risePulse);
endinterface : vid_if
